// ### core/flash_write_command_status.sv
`timescale 1ns/1ps
module flash_write_command_status
  import flash_cmd_pkg::*;
#(
  parameter int          ADDR_BITS   = ADDR_W,
  parameter int          PROG_CYCLES = PROG_CYC,
  parameter int          ERASE_CYCLES = ERASE_CYC,
  parameter int          SECTOR_BITS = 12,
  parameter int          BLOCK_BITS  = 16,
  parameter logic [7:0]  MAKER_CODE  = 8'h3c, // value is arbitrary
  parameter logic [7:0]  DEVICE_CODE = 8'h4d  // value is arbitrary
) (
  // clock and reset
  input  wire logic                 i_clock,
  input  wire logic                 i_srst,
  // parallel bus strobes and mode
  input  wire logic                 i_parallel_programming_mode,
  input  wire logic                 i_we_n,
  input  wire logic                 i_oe_n,
  input  wire logic [ADDR_BITS-1:0] i_addr,
  input  wire logic [7:0]           i_wdata,
  // read data back from the array
  input  wire logic [7:0]           i_array_rdata,
  // read path
  output logic [7:0]                o_rdata,
  // array write port
  output logic                      o_array_we,
  output logic [ADDR_BITS-1:0]      o_array_addr,
  output logic [7:0]                o_array_wdata,
  // erase request
  output logic                      o_erase,
  output logic [1:0]                o_erase_kind,
  // status
  output logic                      o_busy,
  output logic                      o_id_mode
);

  // sequencer states
  typedef enum logic [2:0] {S_IDLE, S_G1, S_G2, S_PROG, S_E3, S_E4, S_E5} seq_t;
  // internal operation in progress
  typedef enum logic [1:0] {B_IDLE, B_PROG, B_ERASE} busy_t;

  // timer wide enough for the longest erase
  localparam int CNT_W = $clog2(ERASE_CYCLES + 1);

  seq_t               seq_ff, nxt_seq;           // command decoder state
  busy_t              bst_ff, nxt_bst;           // internal operation state
  logic [CNT_W-1:0]   cnt_ff, nxt_cnt;           // operation timer
  logic [7:0]         glen_ff, nxt_glen;         // strobe low width
  logic               we_n_ff, nxt_we_n;         // previous strobe level
  logic               oe_n_ff, nxt_oe_n;         // previous output enable
  logic               tog_ff, nxt_tog;           // alternating status bit
  logic [7:0]         pdata_ff, nxt_pdata;       // byte being programmed
  logic               id_ff, nxt_id;             // identification mode
  logic [7:0]         rdata_ff, nxt_rdata;       // read data register
  logic               awe_ff, nxt_awe;           // array write pulse
  logic [ADDR_BITS-1:0] aaddr_ff, nxt_aaddr;     // array address
  logic [7:0]         awd_ff, nxt_awd;           // array write data
  logic               ers_ff, nxt_ers;           // erase pulse
  logic [1:0]         ekind_ff, nxt_ekind;       // erase kind
  logic               wr_take;                   // accepted write strobe
  wr_cycle_t          cyc;                       // write being decoded
  logic               at_5555, at_2aaa;          // guard offsets hit
  logic               rd_edge;                   // start of a read

  // one decoded write cycle; guard offsets use the low sixteen bits
  assign cyc     = '{addr: ADDR_W'(i_addr), data: i_wdata};
  assign at_5555 = cyc.addr[15:0] == OFS_5555;
  assign at_2aaa = cyc.addr[15:0] == OFS_2AAA;
  // rising strobe after a long enough low, not in write inhibit
  assign wr_take = i_we_n && !we_n_ff && (glen_ff >= 8'(GLITCH_CYC))
                   && oe_n_ff && i_oe_n;
  // oe falling with strobe high starts a read
  assign rd_edge = !i_oe_n && oe_n_ff && i_we_n;

  // next state of decoder, timer and status
  always_comb begin
    nxt_seq   = seq_ff;
    nxt_bst   = bst_ff;
    nxt_cnt   = cnt_ff;
    nxt_we_n  = i_we_n;
    nxt_oe_n  = i_oe_n;
    // strobe low width saturates so long lows never wrap
    nxt_glen  = i_we_n ? 8'h00 : (glen_ff == 8'hff ? glen_ff : glen_ff + 8'h01);
    nxt_tog   = tog_ff;
    nxt_pdata = pdata_ff;
    nxt_id    = id_ff;
    nxt_rdata = rdata_ff;
    nxt_awe   = 1'b0;
    nxt_aaddr = aaddr_ff;
    nxt_awd   = awd_ff;
    nxt_ers   = 1'b0;
    nxt_ekind = ekind_ff;
    // operation timer
    if (bst_ff != B_IDLE) begin
      if (cnt_ff == '0) begin
        nxt_bst = B_IDLE;
      end else begin
        nxt_cnt = cnt_ff - CNT_W'(1);
      end
    end
    // command decode only when idle
    if (wr_take && bst_ff == B_IDLE) begin
      nxt_seq = S_IDLE;
      unique case (seq_ff)
        S_IDLE: begin
          if (cyc.data == CMD_ID_OUT) begin
            nxt_id = 1'b0;
          end else if (at_5555 && cyc.data == CMD_AA) begin
            nxt_seq = S_G1;
          end
        end
        S_G1: if (at_2aaa && cyc.data == CMD_55) nxt_seq = S_G2;
        S_G2: begin
          if (at_5555) begin
            unique case (cyc.data)
              CMD_PROG:   nxt_seq = S_PROG;
              CMD_ERASE:  nxt_seq = S_E3;
              CMD_ID_IN:  nxt_id  = 1'b1;
              CMD_ID_OUT: nxt_id  = 1'b0;
              default:    nxt_seq = S_IDLE;
            endcase
          end
        end
        S_PROG: begin
          // fourth strobe starts the program
          nxt_bst   = B_PROG;
          nxt_cnt   = CNT_W'(PROG_CYCLES - 1);
          nxt_pdata = cyc.data;
          nxt_awe   = 1'b1;
          nxt_aaddr = cyc.addr[ADDR_BITS-1:0];
          nxt_awd   = cyc.data;
        end
        S_E3: if (at_5555 && cyc.data == CMD_AA) nxt_seq = S_E4;
        S_E4: if (at_2aaa && cyc.data == CMD_55) nxt_seq = S_E5;
        S_E5: begin
          // sixth strobe starts the erase
          nxt_aaddr = cyc.addr[ADDR_BITS-1:0];
          if (cyc.data == CMD_SECTOR) begin
            nxt_ekind = OP_SECTOR;
            nxt_ers   = 1'b1;
          end else if (cyc.data == CMD_BLOCK) begin
            nxt_ekind = OP_BLOCK;
            nxt_ers   = 1'b1;
          end else if (cyc.data == CMD_CHIP && at_5555 &&
                       i_parallel_programming_mode) begin
            nxt_ekind = OP_CHIP;
            nxt_ers   = 1'b1;
          end
          // any accepted erase kind starts the timer
          if (nxt_ers) begin
            nxt_bst = B_ERASE;
            nxt_cnt = CNT_W'(ERASE_CYCLES - 1);
            nxt_awd = ERASED_BYTE;
          end
        end
      endcase
    end
    // read path: status while busy, id codes, else array
    if (rd_edge) begin
      unique case (bst_ff)
        B_PROG: begin
          nxt_rdata = {~pdata_ff[7], tog_ff, 6'h00};
          nxt_tog   = ~tog_ff;
        end
        B_ERASE: begin
          nxt_rdata = {1'b0, tog_ff, 6'h00};
          nxt_tog   = ~tog_ff;
        end
        B_IDLE: begin
          if (id_ff && i_addr[ADDR_BITS-1:1] == '0) begin
            nxt_rdata = i_addr[0] ? DEVICE_CODE : MAKER_CODE;
          end else begin
            nxt_rdata = i_array_rdata;
          end
        end
        default: nxt_rdata = rdata_ff;
      endcase
    end
  end

  // register all state; reset gives normal array read
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      seq_ff   <= S_IDLE;
      bst_ff   <= B_IDLE;
      cnt_ff   <= '0;
      glen_ff  <= 8'h00;
      we_n_ff  <= 1'b1;
      oe_n_ff  <= 1'b1;
      tog_ff   <= 1'b0;
      pdata_ff <= RST_BYTE;
      id_ff    <= 1'b0;
      rdata_ff <= RST_BYTE;
      awe_ff   <= 1'b0;
      aaddr_ff <= '0;
      awd_ff   <= RST_BYTE;
      ers_ff   <= 1'b0;
      ekind_ff <= 2'h0;
    end else begin
      seq_ff   <= nxt_seq;
      bst_ff   <= nxt_bst;
      cnt_ff   <= nxt_cnt;
      glen_ff  <= nxt_glen;
      we_n_ff  <= nxt_we_n;
      oe_n_ff  <= nxt_oe_n;
      tog_ff   <= nxt_tog;
      pdata_ff <= nxt_pdata;
      id_ff    <= nxt_id;
      rdata_ff <= nxt_rdata;
      awe_ff   <= nxt_awe;
      aaddr_ff <= nxt_aaddr;
      awd_ff   <= nxt_awd;
      ers_ff   <= nxt_ers;
      ekind_ff <= nxt_ekind;
    end
  end

  // outputs from flip-flops
  assign o_rdata       = rdata_ff;
  assign o_array_we    = awe_ff;
  assign o_array_addr  = aaddr_ff;
  assign o_array_wdata = awd_ff;
  assign o_erase       = ers_ff;
  assign o_erase_kind  = ekind_ff;
  assign o_busy        = bst_ff != B_IDLE;
  assign o_id_mode     = id_ff;

  // checks
  // status reads while an operation runs
  prog_poll_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (rd_edge && bst_ff == B_PROG) |=> o_rdata[7] == ~pdata_ff[7])
    else $error("program poll bit not complemented");
  erase_poll_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (rd_edge && bst_ff == B_ERASE) |=> o_rdata[7] == 1'b0)
    else $error("erase poll bit not zero");
  toggle_bit_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (rd_edge && bst_ff != B_IDLE) |=> tog_ff != $past(tog_ff))
    else $error("status bit did not alternate");
  // write filters
  glitch_rej_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (glen_ff < 8'(GLITCH_CYC)) |-> !wr_take)
    else $error("short strobe accepted");
  inhibit_wr_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (!i_oe_n || !oe_n_ff) |=> !o_array_we && !o_erase)
    else $error("write taken during inhibit");
  // command effects
  busy_ignore_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (o_busy && nxt_bst != B_IDLE) |=> !o_array_we && !o_erase)
    else $error("command acted on while busy");
  chip_pp_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (o_erase && o_erase_kind == OP_CHIP) |-> $past(i_parallel_programming_mode))
    else $error("chip erase outside parallel mode");
  prog_start_a: assert property (@(posedge i_clock) disable iff (i_srst)
    o_array_we |-> o_busy && $past(seq_ff) == S_PROG)
    else $error("program without guard sequence");
  erase_ones_a: assert property (@(posedge i_clock) disable iff (i_srst)
    o_erase |-> o_array_wdata == ERASED_BYTE)
    else $error("erase value not all ones");
  id_exit_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (wr_take && !o_busy && seq_ff == S_IDLE && i_wdata == CMD_ID_OUT) |=> !o_id_mode)
    else $error("id mode not left");
  seq_drop_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (wr_take && bst_ff == B_IDLE && seq_ff == S_G1 && !(at_2aaa && cyc.data == CMD_55))
    |=> seq_ff == S_IDLE)
    else $error("broken sequence kept");
  erase_start_a: assert property (@(posedge i_clock) disable iff (i_srst)
    o_erase |-> o_busy && $past(seq_ff) == S_E5)
    else $error("erase without guard sequence");
  toggle_hold_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (rd_edge && bst_ff == B_IDLE) |=> tog_ff == $past(tog_ff))
    else $error("status bit alternated while idle");
  id_reset_a: assert property (@(posedge i_clock)
    ($past(i_srst) && !i_srst) |-> !o_id_mode && !o_busy)
    else $error("reset left id mode or busy");

  // coverage of the main scenarios
  prog_cov: cover property (@(posedge i_clock) disable iff (i_srst) o_array_we);
  erase_cov: cover property (@(posedge i_clock) disable iff (i_srst) o_erase);
  id_cov: cover property (@(posedge i_clock) disable iff (i_srst) $rose(o_id_mode));
  done_cov: cover property (@(posedge i_clock) disable iff (i_srst) $fell(o_busy));
  chip_cov: cover property (@(posedge i_clock) disable iff (i_srst)
    o_erase && o_erase_kind == OP_CHIP);

endmodule

// ### core/flash_cmd_pkg.sv
package flash_cmd_pkg;
  // address and data widths
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  // guard sequence offsets
  localparam logic [15:0] OFS_5555 = 16'h5555;
  localparam logic [15:0] OFS_2AAA = 16'h2aaa;
  // command codes
  localparam logic [7:0] CMD_AA     = 8'haa;
  localparam logic [7:0] CMD_55     = 8'h55;
  localparam logic [7:0] CMD_PROG   = 8'ha0;
  localparam logic [7:0] CMD_ERASE  = 8'h80;
  localparam logic [7:0] CMD_ID_IN  = 8'h90;
  localparam logic [7:0] CMD_ID_OUT = 8'hf0;
  localparam logic [7:0] CMD_SECTOR = 8'h30;
  localparam logic [7:0] CMD_BLOCK  = 8'h50;
  localparam logic [7:0] CMD_CHIP   = 8'h10;
  // erased byte value
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // timing in the unit printed
  localparam int CLK_MHZ        = 25;
  localparam int GLITCH_NS      = 5;
  localparam int SETTLE_US      = 1;
  localparam int PROG_US        = 20;
  localparam int ERASE_MS       = 18;
  // least times round up to whole cycles
  localparam int GLITCH_CYC = (GLITCH_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 :
                              (GLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int PROG_CYC   = PROG_US * CLK_MHZ;
  localparam int ERASE_CYC  = ERASE_MS * 1000 * CLK_MHZ;
  // one bus write as seen by the sequencer
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } wr_cycle_t;
  // kinds of internal operation
  typedef enum logic [1:0] {OP_PROG, OP_SECTOR, OP_BLOCK, OP_CHIP} op_kind_t;
endpackage

// ### sim/flash_array_model.sv
`timescale 1ns/1ps
// array behind the sequencer: 256 bytes, starts erased
module flash_array_model (
  // clock
  input  wire logic        i_clock,
  // program and erase requests
  input  wire logic        i_we,
  input  wire logic [18:0] i_waddr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_erase,
  // read path
  input  wire logic [18:0] i_raddr,
  output logic [7:0]       o_rdata
);
  logic [7:0] mem_ff [256]; // byte store
  initial foreach (mem_ff[i]) mem_ff[i] = 8'hff;
  // any erase wipes the whole model, which lies inside one sector
  always @(posedge i_clock) begin
    if (i_erase) foreach (mem_ff[i]) mem_ff[i] <= 8'hff;
    else if (i_we) mem_ff[i_waddr[7:0]] <= i_wdata;
  end
  assign o_rdata = mem_ff[i_raddr[7:0]];
endmodule

// ### sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import flash_cmd_pkg::*;
  localparam logic [7:0]  MK = 8'h5a; // arbitrary value
  localparam logic [7:0]  DV = 8'ha7; // arbitrary value
  localparam logic [18:0] A5 = {3'h0, OFS_5555};
  localparam logic [18:0] A2 = {3'h0, OFS_2AAA};
  logic        i_clock, i_srst, pp, we_n, oe_n, rd_done, a_we, erase, busy, idm, w, e, prev6;
  logic [18:0] addr, a_addr, a;
  logic [7:0]  wdata, ardata, rdata, a_wdata, d;
  logic [1:0]  ekind, ek;
  logic [9:0]  expq[$]; // {mode, byte}: mode 2 notes bit six, mode 1 wants it inverted
  logic [9:0]  ex;
  logic [31:0] rs = 32'hfdfa;
  logic [31:0] r;
  int          miscompares, cmp_count;
  flash_write_command_status #(.PROG_CYCLES(20), .ERASE_CYCLES(40), .MAKER_CODE(MK),
    .DEVICE_CODE(DV)) flash_write_command_status_inst (.i_clock(i_clock), .i_srst(i_srst),
    .i_parallel_programming_mode(pp), .i_we_n(we_n), .i_oe_n(oe_n), .i_addr(addr),
    .i_wdata(wdata), .i_array_rdata(ardata), .o_rdata(rdata), .o_array_we(a_we),
    .o_array_addr(a_addr), .o_array_wdata(a_wdata), .o_erase(erase), .o_erase_kind(ekind),
    .o_busy(busy), .o_id_mode(idm));
  flash_array_model flash_array_model_inst (.i_clock(i_clock), .i_we(a_we), .i_waddr(a_addr),
    .i_wdata(a_wdata), .i_erase(erase), .i_raddr(addr), .o_rdata(ardata));
  // 25 MHz clock
  initial begin
    i_clock = 0;
    forever #20 i_clock = ~i_clock;
  end
  // xorshift source
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  // compare and count
  task automatic chk(string n, logic [7:0] s, logic [7:0] x);
    cmp_count++;
    if (s !== x) begin
      miscompares++;
      $display("unexpected %s exp %h seen %h", n, x, s);
    end
  endtask
  // verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one write strobe; oe low on it must make it refused
  task automatic wr(logic [18:0] ad, logic [7:0] dt, logic oe = 1'b1);
    addr = ad;
    wdata = dt;
    oe_n = oe;
    we_n = 0;
    @(posedge i_clock);
    #1 we_n = 1;
    oe_n = 1;
    @(posedge i_clock);
    #1;
  endtask
  // three guard cycles ending with a command
  task automatic g3(logic [7:0] c);
    wr(A5, CMD_AA);
    wr(A2, CMD_55);
    wr(A5, c);
  endtask
  // read cycle; expectation goes to the queue
  task automatic rd(logic [18:0] ad, logic [9:0] x);
    addr = ad;
    oe_n = 0;
    @(posedge i_clock);
    @(posedge i_clock);
    #1 expq.push_back(x);
    rd_done = 1;
    oe_n = 1;
    @(posedge i_clock);
    #1 rd_done = 0;
  endtask
  // bounded wait for busy low, then extra cycles
  task automatic idle(int s);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 200) begin
      @(posedge i_clock);
      #1 n++;
    end
    chk("busy wait", {7'h0, n >= 200}, 8'h00);
    repeat (s) begin
      @(posedge i_clock);
      #1;
    end
  endtask
  // collect the one-cycle pulses over two cycles
  task automatic seen();
    w = a_we;
    e = erase;
    ek = ekind;
    @(posedge i_clock);
    #1 w |= a_we;
    e |= erase;
    if (erase) ek = ekind;
  endtask
  // result watcher pops the oldest note
  always @(posedge i_clock) begin
    if (rd_done) begin
      ex = expq.pop_front();
      if (ex[9]) ex[6] = rdata[6];
      if (ex[8]) ex[6] = ~prev6;
      chk("read data", rdata, ex[7:0]);
      prev6 = rdata[6];
    end
  end
  // watchdog
  initial begin
    #(20000 * 40);
    miscompares++;
    report_and_stop();
  end
  // main sequence
  initial begin
    pp = 1;
    we_n = 1;
    oe_n = 1;
    addr = 0;
    wdata = 0;
    rd_done = 0;
    i_srst = 1;
    prev6 = 0;
    repeat (8) @(posedge i_clock);
    #1 i_srst = 0;
    chk("id after reset", {7'h0, idm}, 8'h00);
    // program, ignored sequence while busy, polling reads
    r = rnd();
    d = r[7:0];
    a = {11'h0, r[15:8] | 8'h80};
    g3(CMD_PROG);
    wr(a, d);
    seen();
    chk("program pulse", {7'h0, w}, 8'h01);
    g3(CMD_PROG);
    wr(a ^ 19'h1, ~d);
    rd(a, {2'b10, ~d[7], 7'h0});
    rd(a, {2'b01, ~d[7], 7'h0});
    idle(SETTLE_CYC);
    rd(a, {2'b00, d});
    rd(a ^ 19'h1, 10'h0ff);
    // broken sequence and inhibited strobe start nothing
    for (int k = 0; k < 2; k++) begin
      wr(A5, CMD_AA);
      wr(A2, CMD_55, k[0]);
      wr(A5, k == 0 ? CMD_PROG : 8'h77);
      wr(a ^ 19'h2, 8'h00);
      chk("busy stray", {7'h0, busy}, 8'h00);
    end
    rd(a ^ 19'h2, 10'h0ff);
    // short strobe is not a fourth cycle
    g3(CMD_PROG);
    we_n = 0;
    #3 we_n = 1;
    @(posedge i_clock);
    #1 chk("busy glitch", {7'h0, busy}, 8'h00);
    wr(a ^ 19'h2, d);
    idle(SETTLE_CYC);
    rd(a ^ 19'h2, {2'b00, d});
    // id entry, reset, both exits
    g3(CMD_ID_IN);
    chk("id entry", {7'h0, idm}, 8'h01);
    rd(19'h0, {2'b00, MK});
    rd(19'h1, {2'b00, DV});
    i_srst = 1;
    repeat (8) @(posedge i_clock);
    #1 i_srst = 0;
    chk("id after reset", {7'h0, idm}, 8'h00);
    rd(19'h0, 10'h0ff);
    g3(CMD_ID_IN);
    wr(a, CMD_ID_OUT);
    chk("single exit", {7'h0, idm}, 8'h00);
    g3(CMD_ID_IN);
    g3(CMD_ID_OUT);
    chk("long exit", {7'h0, idm}, 8'h00);
    // sector, block, chip erase, then chip erase outside parallel mode
    for (int k = 0; k < 4; k++) begin
      r = rnd();
      g3(CMD_PROG);
      wr(a, r[7:0]);
      idle(SETTLE_CYC);
      pp = (k != 3);
      g3(CMD_ERASE);
      wr(A5, CMD_AA);
      wr(A2, CMD_55);
      wr(k < 2 ? a : A5, k == 0 ? CMD_SECTOR : k == 1 ? CMD_BLOCK : CMD_CHIP);
      seen();
      chk("erase pulse", {7'h0, e}, {7'h0, k != 3});
      if (k == 3) begin
        idle(0);
        rd(a, {2'b00, r[7:0]});
      end else begin
        chk("erase kind", {6'h0, ek}, 8'(k + 1));
        rd(a, 10'h200);
        rd(a, 10'h100);
        idle(SETTLE_CYC);
        rd(a, 10'h0ff);
      end
    end
    @(posedge i_clock);
    #1 report_and_stop();
  end
endmodule
